// [inc/adccr_defs.svh]
`ifndef ADCCR_DEFS_SVH
`define ADCCR_DEFS_SVH

// Register byte offsets on the APB.
`define ADCCR_OFF_SC1       8'h00
`define ADCCR_OFF_SC2       8'h04
`define ADCCR_OFF_RH        8'h08
`define ADCCR_OFF_RL        8'h0C
`define ADCCR_OFF_CVH       8'h10
`define ADCCR_OFF_CVL       8'h14
`define ADCCR_OFF_CFG       8'h18
`define ADCCR_OFF_ISTAT     8'h1C
`define ADCCR_OFF_IMASK     8'h20

// Field positions.
`define ADCCR_SC1_CONVERSION_COMPLETE_FLAG      7
`define ADCCR_SC1_CONT      5
`define ADCCR_SC2_ACT       7
`define ADCCR_SC2_TRIG      6
`define ADCCR_SC2_CMPEN     5
`define ADCCR_SC2_CMPGE     4
`define ADCCR_CFG_VALID     7
`define ADCCR_CFG_MODE_LO   2
`define ADCCR_IRQ_DONE      0
`define ADCCR_IRQ_LOST      1

// Encodings and reset values.
`define ADCCR_CHAN_OFF      5'h1F
`define ADCCR_MODE_TEN      2'h2
`define ADCCR_RST_CHAN      5'h1F
`define ADCCR_RST_MODE      2'h0
`define ADCCR_RST_MASK      2'h0

`endif

// [inc/adccr_pkg.sv]
package adccr_pkg;

    typedef enum logic [1:0] {
        ADCCR_IDLE = 2'h1,
        ADCCR_CONV = 2'h2
    } adccr_conv_t;

    typedef struct packed {
        adccr_conv_t st;
        logic [4:0]  chan;
        logic        cont;
        logic        conversion_complete_flag;
        logic        trig;
        logic        cmp_en;
        logic        cmp_ge;
        logic [1:0]  mode;
        logic [1:0]  cvh;
        logic [7:0]  cvl;
        logic [1:0]  rh;
        logic [7:0]  rl;
        logic        lock;
        logic        valid;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [31:0] rdata;
        logic        slverr;
        logic        start;
        logic        abort;
    } adccr_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } adccr_sync_t;

endpackage

// [inc/adccr_cmp_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface adccr_cmp_if;
    logic       clk;
    logic       rst;
    logic [9:0] result;
    logic [9:0] cv;
    logic       ten_bit;
    logic       en;
    logic       ge;
    logic       hit;

    modport ctl (output clk, rst, result, cv, ten_bit, en, ge, input hit);
    modport cmp (input clk, rst, result, cv, ten_bit, en, ge, output hit);
endinterface

`default_nettype wire

// [src/adccr_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module adccr_sync (
    input  wire logic mclk_i,      // Bus clock.
    input  wire logic sys_rst_i,   // Synchronous reset, active high.
    input  wire logic async_i,     // Level from another domain.
    output logic      rise_o       // One-cycle pulse on a rising edge.
);
    adccr_pkg::adccr_sync_t q;
    adccr_pkg::adccr_sync_t d;

    always_comb begin
        d    = q;
        d.s1 = async_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Only the second stage and its delayed copy feed the edge detector.
    assign rise_o = q.s2 & ~q.s3;

    AST_SYNC_PULSE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rise_o |=> !rise_o)
        else $error("trigger pulse lasted more than one cycle");
endmodule

`default_nettype wire

// [src/adccr_cmp.sv]
`timescale 1ns/1ps
`default_nettype none

module adccr_cmp (
    adccr_cmp_if.cmp c   // Compare request and answer.
);
    logic [9:0] res_w;
    logic [9:0] ref_w;
    logic       ge_w;

    always_comb begin
        // The upper compare bits only take part in 10-bit mode.
        res_w = c.ten_bit ? c.result : {2'h0, c.result[7:0]};
        ref_w = c.ten_bit ? c.cv : {2'h0, c.cv[7:0]};
        ge_w  = res_w >= ref_w;
        if (!c.en) begin
            c.hit = 1'b1;
        end else begin
            c.hit = c.ge ? ge_w : ~ge_w;
        end
    end

    AST_CMP_OFF: assert property (@(posedge c.clk) disable iff (c.rst)
        !c.en |-> c.hit)
        else $error("compare blocked a result while disabled");

    AST_CMP_GE: assert property (@(posedge c.clk) disable iff (c.rst)
        (c.en && c.ge && c.ten_bit) |-> (c.hit == (c.result >= c.cv)))
        else $error("greater-or-equal compare wrong");

    AST_CMP_LT8: assert property (@(posedge c.clk) disable iff (c.rst)
        (c.en && !c.ge && !c.ten_bit) |-> (c.hit == (c.result[7:0] < c.cv[7:0])))
        else $error("8-bit less-than compare wrong");
endmodule

`default_nettype wire

// [src/adccr_top.sv]
// Contract
// - Active flag is set when a conversion starts, cleared on completion or abort.
// - Trigger select 0 starts on status_control_one write, 1 on hardware trigger.
// - Automatic compare works only while compare_enable is set.
// - Greater-equal bit picks result >= value, otherwise result < value.
// - Result high holds bits nine and eight; reads zero in 8-bit mode.
// - Results load on completion unless compare is enabled and false.
// - 10-bit mode: reading high blocks new results until low is read.
// - 8-bit mode: reads engage no interlock; results always transfer.
// - A resolution mode change makes both result registers invalid.
// - Result low holds bits seven to zero, or the whole 8-bit result.
// - 10-bit compare uses compare-value high bits against result high bits.
// - Compare-value low bits compare with result low bits in both modes.
// - Complete flag sets only on a true compare when compare is enabled.
// - Writing status_control_one aborts; restarts unless channel is all ones.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "adccr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module adccr_top #(
    parameter int ADDR_W = 8                  // APB address width.
) (
    input  wire logic              mclk_i,        // Bus clock, 50 MHz.
    input  wire logic              sys_rst_i,     // Synchronous reset, active high.
    input  wire logic              psel,          // APB select.
    input  wire logic              penable,       // APB access phase.
    input  wire logic              pwrite,        // APB direction.
    input  wire logic [ADDR_W-1:0] paddr,         // APB byte address.
    input  wire logic [31:0]       pwdata,        // APB write data.
    output logic      [31:0]       prdata,        // APB read data.
    output logic                   pready,        // APB ready.
    output logic                   pslverr,       // APB error on unmapped address.
    input  wire logic              hw_trig_i,     // Hardware trigger input.
    output logic                   conv_start_o,  // Start pulse to the analog core.
    output logic                   conv_abort_o,  // Abort pulse to the analog core.
    output logic      [4:0]        conv_chan_o,   // Channel for the analog core.
    output logic                   conv_ten_o,    // High for 10-bit conversions.
    input  wire logic              conv_done_i,   // Completion pulse from the core.
    input  wire logic [9:0]        conv_data_i,   // Result; 8-bit results in bits 7:0.
    output logic                   irq_o          // Level interrupt.
);
    if (ADDR_W < 6) begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    adccr_pkg::adccr_state_t q;
    adccr_pkg::adccr_state_t d;
    adccr_cmp_if             cif ();

    logic             hw_rise;
    logic             acc;
    logic             wr;
    logic             rd;
    logic             setup;
    logic [7:0]       a_acc;
    logic [7:0]       a_set;
    logic             ten_bit;
    logic             done;
    logic             wr_sc1;
    logic [1:0]       new_mode;
    logic             mode_chg;

    default clocking cb_main @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    adccr_sync u_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (hw_trig_i),
        .rise_o    (hw_rise)
    );

    assign cif.clk     = mclk_i;
    assign cif.rst     = sys_rst_i;
    assign cif.result  = conv_data_i;
    assign cif.cv      = {q.cvh, q.cvl};
    assign cif.ten_bit = ten_bit;
    assign cif.en      = q.cmp_en;
    assign cif.ge      = q.cmp_ge;

    adccr_cmp u_cmp (
        .c (cif.cmp)
    );

    assign ten_bit  = q.mode == `ADCCR_MODE_TEN;
    assign setup    = psel & ~penable;
    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    assign rd       = acc & ~pwrite;
    assign a_acc    = 8'(paddr);
    assign a_set    = 8'(paddr);
    assign done     = (q.st == adccr_pkg::ADCCR_CONV) & conv_done_i;
    assign wr_sc1   = wr & (a_acc == `ADCCR_OFF_SC1);
    assign new_mode = pwdata[`ADCCR_CFG_MODE_LO +: 2];
    // A resolution change voids any result that completes in the same cycle.
    assign mode_chg = wr & (a_acc == `ADCCR_OFF_CFG) & (new_mode != q.mode);

    always_comb begin
        d       = q;
        d.start = 1'b0;
        d.abort = 1'b0;

        // Read data are captured in the setup phase so prdata comes from a flop.
        if (setup) begin
            d.slverr = 1'b0;
            unique case (a_set)
                `ADCCR_OFF_SC1:   d.rdata = {24'h0, q.conversion_complete_flag, 1'b0, q.cont, q.chan};
                `ADCCR_OFF_SC2:   d.rdata = {24'h0, q.st == adccr_pkg::ADCCR_CONV,
                                             q.trig, q.cmp_en, q.cmp_ge, 4'h0};
                `ADCCR_OFF_RH:    d.rdata = {30'h0, q.rh};
                `ADCCR_OFF_RL:    d.rdata = {24'h0, q.rl};
                `ADCCR_OFF_CVH:   d.rdata = {30'h0, q.cvh};
                `ADCCR_OFF_CVL:   d.rdata = {24'h0, q.cvl};
                `ADCCR_OFF_CFG:   d.rdata = {24'h0, q.valid, 3'h0, q.mode, 2'h0};
                `ADCCR_OFF_ISTAT: d.rdata = {30'h0, q.irq_stat};
                `ADCCR_OFF_IMASK: d.rdata = {30'h0, q.irq_mask};
                default: begin
                    d.rdata  = 32'h0;
                    d.slverr = 1'b1;
                end
            endcase
        end

        // Read side effects come first so that a same-cycle event still sets its flag.
        if (rd) begin
            if (a_acc == `ADCCR_OFF_RH && ten_bit) begin
                d.lock = 1'b1;
            end
            if (a_acc == `ADCCR_OFF_RL) begin
                d.lock = 1'b0;
                d.conversion_complete_flag = 1'b0;
            end
            if (a_acc == `ADCCR_OFF_ISTAT) begin
                d.irq_stat = 2'h0;
            end
        end

        if (wr) begin
            unique case (a_acc)
                `ADCCR_OFF_SC2: begin
                    // Bits 3:0 are reserved; whatever software puts there is dropped.
                    d.trig   = pwdata[`ADCCR_SC2_TRIG];
                    d.cmp_en = pwdata[`ADCCR_SC2_CMPEN];
                    d.cmp_ge = pwdata[`ADCCR_SC2_CMPGE];
                end
                `ADCCR_OFF_CVH:   d.cvh      = pwdata[1:0];
                `ADCCR_OFF_CVL:   d.cvl      = pwdata[7:0];
                `ADCCR_OFF_IMASK: d.irq_mask = pwdata[1:0];
                `ADCCR_OFF_CFG: begin
                    d.mode = new_mode;
                    if (new_mode != q.mode) begin
                        d.rh    = 2'h0;
                        d.rl    = 8'h0;
                        d.valid = 1'b0;
                        d.lock  = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        if (wr_sc1) begin
            // A write aborts a running conversion; a result landing in the same cycle is dropped.
            d.chan = pwdata[4:0];
            d.cont = pwdata[`ADCCR_SC1_CONT];
            d.conversion_complete_flag = 1'b0;
            d.st   = adccr_pkg::ADCCR_IDLE;
            if (q.st == adccr_pkg::ADCCR_CONV) begin
                d.abort = 1'b1;
            end
            if (!q.trig && pwdata[4:0] != `ADCCR_CHAN_OFF) begin
                d.st    = adccr_pkg::ADCCR_CONV;
                d.start = 1'b1;
            end
        end else if (done) begin
            d.st = adccr_pkg::ADCCR_IDLE;
            if (cif.hit) begin
                d.conversion_complete_flag                    = 1'b1;
                d.irq_stat[`ADCCR_IRQ_DONE] = 1'b1;
                // A result that finishes under a mode being replaced is dropped.
                if (q.lock) begin
                    d.irq_stat[`ADCCR_IRQ_LOST] = 1'b1;
                end else if (!mode_chg) begin
                    d.rh    = ten_bit ? conv_data_i[9:8] : 2'h0;
                    d.rl    = conv_data_i[7:0];
                    d.valid = 1'b1;
                end
            end
            // Continuous mode in software trigger restarts at once.
            if (q.cont && !q.trig && q.chan != `ADCCR_CHAN_OFF) begin
                d.st    = adccr_pkg::ADCCR_CONV;
                d.start = 1'b1;
            end
        end else if (q.trig && hw_rise && q.st == adccr_pkg::ADCCR_IDLE
                     && q.chan != `ADCCR_CHAN_OFF) begin
            d.st    = adccr_pkg::ADCCR_CONV;
            d.start = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            q          <= '0;
            q.st       <= adccr_pkg::ADCCR_IDLE;
            q.chan     <= `ADCCR_RST_CHAN;
            q.mode     <= `ADCCR_RST_MODE;
            q.irq_mask <= `ADCCR_RST_MASK;
        end else begin
            q <= d;
        end
    end

    assign prdata       = q.rdata;
    assign pslverr      = q.slverr & acc;
    assign pready       = 1'b1;
    assign conv_start_o = q.start;
    assign conv_abort_o = q.abort;
    assign conv_chan_o  = q.chan;
    assign conv_ten_o   = ten_bit;
    assign irq_o        = |(q.irq_stat & q.irq_mask);

    sequence s_sw_write;
        wr_sc1 && !q.trig && pwdata[4:0] != `ADCCR_CHAN_OFF;
    endsequence

    sequence s_started;
        q.start && q.st == adccr_pkg::ADCCR_CONV;
    endsequence

    AST_SW_START: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_sw_write |=> s_started)
        else $error("software write did not start a conversion");

    AST_HW_START: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (q.trig && hw_rise && q.st == adccr_pkg::ADCCR_IDLE && !wr_sc1
         && q.chan != `ADCCR_CHAN_OFF) |=> s_started)
        else $error("hardware trigger did not start a conversion");

    AST_OFF_ABORT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (wr_sc1 && pwdata[4:0] == `ADCCR_CHAN_OFF) |=>
        (q.st == adccr_pkg::ADCCR_IDLE && !q.start))
        else $error("disabled channel still converted");

    AST_ACTIVE_CLR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (done && !wr_sc1 && !q.cont) |=> q.st == adccr_pkg::ADCCR_IDLE)
        else $error("active flag stayed after completion");

    AST_CONVERSION_COMPLETE_FLAG_HIT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (done && !wr_sc1) |=> (q.conversion_complete_flag == $past(cif.hit) || $past(q.conversion_complete_flag)))
        else $error("complete flag does not follow compare");

    AST_KEEP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (done && !cif.hit && !wr) |=> $stable(q.rl) && $stable(q.rh))
        else $error("result loaded on false compare");

    AST_LOCK: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (done && q.lock && !wr) |=> $stable(q.rl) ##0
        (q.irq_stat[`ADCCR_IRQ_LOST] == 1'b1 || !$past(cif.hit)))
        else $error("locked result was overwritten");

    AST_NO_LOCK8: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !ten_bit |-> !q.lock)
        else $error("interlock engaged in 8-bit mode");

    AST_RH8: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !ten_bit |-> q.rh == 2'h0)
        else $error("high result bits nonzero in 8-bit mode");

    AST_MODE_INV: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (wr && a_acc == `ADCCR_OFF_CFG && new_mode != q.mode) |=>
        (!q.valid && q.rl == 8'h0))
        else $error("mode change left results valid");

    sequence s_abort_req;
        wr_sc1 && q.st == adccr_pkg::ADCCR_CONV;
    endsequence

    // The checks below use the default clock and reset declared at the top.
    AST_ABORT: assert property (
        s_abort_req
        |=> q.abort)
        else $error("running conversion not aborted");

    AST_ACT_START: assert property (
        q.start
        |-> q.st == adccr_pkg::ADCCR_CONV)
        else $error("start pulse without active flag");

    AST_CONVERSION_COMPLETE_FLAG_WR: assert property (
        wr_sc1
        |=> !q.conversion_complete_flag)
        else $error("complete flag kept after control write");

    AST_CONVERSION_COMPLETE_FLAG_RL: assert property (
        (rd && a_acc == `ADCCR_OFF_RL && !done)
        |=> !q.conversion_complete_flag)
        else $error("complete flag kept after result read");

    AST_CONVERSION_COMPLETE_FLAG_OFF: assert property (
        (done && !wr_sc1 && !q.cmp_en)
        |=> q.conversion_complete_flag)
        else $error("complete flag missed with compare off");

    AST_LOAD_LO: assert property (
        (done && !wr && cif.hit && !q.lock)
        |=> q.valid && q.rl == $past(conv_data_i[7:0]))
        else $error("result low not loaded");

    AST_LOAD_HI: assert property (
        (done && !wr && cif.hit && !q.lock && ten_bit)
        |=> q.rh == $past(conv_data_i[9:8]))
        else $error("result high not loaded");

    AST_LOCK_SET: assert property (
        (rd && a_acc == `ADCCR_OFF_RH && ten_bit)
        |=> q.lock)
        else $error("high read did not lock");

    AST_LOCK_CLR: assert property (
        (rd && a_acc == `ADCCR_OFF_RL)
        |=> !q.lock)
        else $error("low read did not unlock");

    AST_LOST: assert property (
        (done && !wr && cif.hit && q.lock)
        |=> q.irq_stat[`ADCCR_IRQ_LOST])
        else $error("discarded result not flagged");

    AST_ISTAT_CLR: assert property (
        (rd && a_acc == `ADCCR_OFF_ISTAT && !done)
        |=> q.irq_stat == 2'h0)
        else $error("status read did not clear");

    AST_NO_SW_START: assert property (
        (!q.trig && !wr_sc1 && !done)
        |=> !q.start)
        else $error("software mode started without a write");

    AST_HW_BUSY: assert property (
        (q.trig && q.st == adccr_pkg::ADCCR_CONV && !done && !wr_sc1)
        |=> !q.start)
        else $error("trigger restarted a running conversion");
endmodule

`default_nettype wire

// [verification/adccr_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module adccr_core_model (
    input  wire logic       mclk_i,     // Bus clock.
    input  wire logic       sys_rst_i,  // Synchronous reset.
    input  wire logic       start_i,    // Start pulse.
    input  wire logic       abort_i,    // Abort pulse.
    input  wire logic       ten_i,      // High for 10-bit results.
    input  wire logic [7:0] dly_i,      // Conversion length in cycles.
    input  wire logic [9:0] val_i,      // Result to deliver.
    output logic            done_o,     // Completion pulse.
    output logic      [9:0] data_o      // Result, valid only with done_o.
);
    logic [7:0] cnt_q;
    logic       busy_q;

    // Between pulses the data lines toggle, so a sample one cycle late is never a stale match.
    always_ff @(posedge mclk_i) begin
        done_o <= 1'b0;
        data_o <= ~data_o;
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            data_o <= 10'h000;
        end else if (start_i) begin
            busy_q <= 1'b1;
            cnt_q  <= dly_i;
        end else if (abort_i) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
                busy_q <= 1'b0;
                done_o <= 1'b1;
                data_o <= ten_i ? val_i : {2'h0, val_i[7:0]};
            end
        end
    end
endmodule

`default_nettype wire

// [verification/tb_adc_compare_result_regs.sv]
`include "adccr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_adc_compare_result_regs;
    logic        mclk_i    = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h00000000;
    logic        hw_trig_i = 1'b0;
    logic [7:0]  dly       = 8'h05;
    logic [9:0]  val       = 10'h000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conv_start_o;
    logic        conv_abort_o;
    logic [4:0]  conv_chan_o;
    logic        conv_ten_o;
    logic        conv_done_i;
    logic [9:0]  conv_data_i;
    logic        irq_o;
    logic [31:0] rd;
    logic        er;
    int          error_cnt   = 0;
    int          comparisons = 0;
    int          starts      = 0;
    int          s0;

    adccr_top #(.ADDR_W(8)) uut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hw_trig_i(hw_trig_i),
        .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
        .conv_chan_o(conv_chan_o), .conv_ten_o(conv_ten_o),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .irq_o(irq_o)
    );

    adccr_core_model u_core (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .start_i(conv_start_o),
        .abort_i(conv_abort_o), .ten_i(conv_ten_o), .dly_i(dly), .val_i(val),
        .done_o(conv_done_i), .data_o(conv_data_i)
    );

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        if (conv_start_o === 1'b1) starts++;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(nm, rd, exp);
    endtask

    task automatic conv(input logic [9:0] v);
        val <= v;
        apb(1'b1, `ADCCR_OFF_SC1, 32'h00000003);
        for (int i = 0; i < 100 && conv_done_i !== 1'b1; i++) @(posedge mclk_i);
        repeat (2) @(posedge mclk_i);
    endtask

    task automatic t_reset();
        rdchk("sc1", `ADCCR_OFF_SC1, 32'h0000001F);
        rdchk("sc2", `ADCCR_OFF_SC2, 32'h00000000);
        rdchk("cfg", `ADCCR_OFF_CFG, 32'h00000000);
        rdchk("imask", `ADCCR_OFF_IMASK, 32'h00000000);
        apb(1'b0, 8'h24, 32'h00000000);
        chk("unmapped_err", {31'h0, er}, 32'h00000001);
        chk("unmapped_data", rd, 32'h00000000);
    endtask

    task automatic t_active_abort();
        val <= 10'h00C;
        dly <= 8'h1E;
        @(negedge mclk_i) s0 = starts;
        apb(1'b1, `ADCCR_OFF_SC1, 32'h00000002);
        rdchk("sc2_active", `ADCCR_OFF_SC2, 32'h00000080);
        apb(1'b1, `ADCCR_OFF_SC1, 32'h00000005);
        repeat (40) @(posedge mclk_i);
        @(negedge mclk_i) chk("restarts", starts - s0, 2);
        rdchk("rl_restart", `ADCCR_OFF_RL, 32'h0000000C);
        apb(1'b1, `ADCCR_OFF_SC1, 32'h00000002);
        repeat (2) @(negedge mclk_i) s0 = starts;
        apb(1'b1, `ADCCR_OFF_SC1, 32'h0000001F);
        rdchk("sc2_aborted", `ADCCR_OFF_SC2, 32'h00000000);
        chk("chan_off", {27'h0, conv_chan_o}, 32'h0000001F);
        repeat (40) @(posedge mclk_i);
        @(negedge mclk_i) chk("no_start", starts - s0, 0);
        rdchk("sc1_no_conversion_complete_flag", `ADCCR_OFF_SC1, 32'h0000001F);
        dly <= 8'h05;
    endtask

    task automatic t_ten_lock();
        apb(1'b1, `ADCCR_OFF_CFG, 32'h00000008);
        apb(1'b0, `ADCCR_OFF_ISTAT, 32'h00000000);
        conv(10'h2C3);
        rdchk("rh_ten", `ADCCR_OFF_RH, 32'h00000002);
        conv(10'h155);
        rdchk("rl_locked", `ADCCR_OFF_RL, 32'h000000C3);
        rdchk("istat_lost", `ADCCR_OFF_ISTAT, 32'h00000003);
        conv(10'h155);
        rdchk("rh_unlocked", `ADCCR_OFF_RH, 32'h00000001);
        rdchk("rl_unlocked", `ADCCR_OFF_RL, 32'h00000055);
    endtask

    task automatic t_eight();
        apb(1'b1, `ADCCR_OFF_CFG, 32'h00000000);
        rdchk("rh_invalid", `ADCCR_OFF_RH, 32'h00000000);
        rdchk("rl_invalid", `ADCCR_OFF_RL, 32'h00000000);
        rdchk("cfg_invalid", `ADCCR_OFF_CFG, 32'h00000000);
        conv(10'h3A5);
        rdchk("rh_eight", `ADCCR_OFF_RH, 32'h00000000);
        conv(10'h05A);
        rdchk("rl_no_lock", `ADCCR_OFF_RL, 32'h0000005A);
        rdchk("cfg_valid", `ADCCR_OFF_CFG, 32'h00000080);
    endtask

    task automatic t_compare();
        logic       en_t  [8] = '{1, 1, 1, 1, 0, 1, 1, 1};
        logic       ten_t [8] = '{1, 1, 1, 1, 1, 0, 0, 0};
        logic       ge_t  [8] = '{1, 1, 0, 0, 0, 1, 0, 0};
        logic       hit_t [8] = '{1, 0, 1, 0, 1, 1, 1, 0};
        logic [9:0] cv_t  [8] = '{10'h200, 10'h200, 10'h200, 10'h155,
                                  10'h000, 10'h310, 10'h310, 10'h010};
        logic [9:0] dat_t [8] = '{10'h200, 10'h1FF, 10'h1FF, 10'h155,
                                  10'h100, 10'h010, 10'h00F, 10'h0F0};
        logic [9:0] prev;
        logic       cur_ten;
        prev    = 10'h05A;
        cur_ten = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (ten_t[i] !== cur_ten) begin
                apb(1'b1, `ADCCR_OFF_CFG, {28'h0, ten_t[i], 3'h0});
                cur_ten = ten_t[i];
                prev    = 10'h000;
            end
            apb(1'b1, `ADCCR_OFF_CVH, {30'h0, cv_t[i][9:8]});
            apb(1'b1, `ADCCR_OFF_CVL, {24'h0, cv_t[i][7:0]});
            apb(1'b1, `ADCCR_OFF_SC2, {26'h0, en_t[i], ge_t[i], 4'h0});
            conv(dat_t[i]);
            if (hit_t[i]) prev = ten_t[i] ? dat_t[i] : {2'h0, dat_t[i][7:0]};
            rdchk("conversion_complete_flag", `ADCCR_OFF_SC1, {24'h0, hit_t[i], 7'h03});
            rdchk("rh_cmp", `ADCCR_OFF_RH, {30'h0, prev[9:8]});
            rdchk("rl_cmp", `ADCCR_OFF_RL, {24'h0, prev[7:0]});
        end
        apb(1'b1, `ADCCR_OFF_SC2, 32'h00000000);
    endtask

    task automatic t_hw();
        apb(1'b1, `ADCCR_OFF_SC2, 32'h00000040);
        val <= 10'h077;
        @(negedge mclk_i) s0 = starts;
        @(posedge mclk_i) hw_trig_i <= 1'b1;
        for (int i = 0; i < 100 && conv_done_i !== 1'b1; i++) @(posedge mclk_i);
        hw_trig_i <= 1'b0;
        @(negedge mclk_i) chk("hw_start", starts - s0, 1);
        rdchk("rl_hw", `ADCCR_OFF_RL, 32'h00000077);
        apb(1'b1, `ADCCR_OFF_SC2, 32'h00000000);
    endtask

    task automatic t_irq();
        apb(1'b1, `ADCCR_OFF_IMASK, 32'h00000001);
        apb(1'b0, `ADCCR_OFF_ISTAT, 32'h00000000);
        conv(10'h012);
        chk("irq_set", {31'h0, irq_o}, 32'h00000001);
        rdchk("istat", `ADCCR_OFF_ISTAT, 32'h00000001);
        @(negedge mclk_i) chk("irq_clr", {31'h0, irq_o}, 32'h00000000);
        apb(1'b1, `ADCCR_OFF_IMASK, 32'h00000000);
        conv(10'h013);
        @(negedge mclk_i) chk("irq_masked", {31'h0, irq_o}, 32'h00000000);
        rdchk("istat_masked", `ADCCR_OFF_ISTAT, 32'h00000001);
    endtask

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The full sequence needs well under 10000 cycles; this bound leaves ample margin.
    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_active_abort();
        t_ten_lock();
        t_eight();
        t_compare();
        t_hw();
        t_irq();
        report_and_stop();
    end
endmodule

`default_nettype wire
